// *** pkg/stm_pkg.sv ***
// Package: constants, field layouts and carrier types of the standard timer
package stm_pkg;

	// ==========================================================
	// Widths
	localparam int ADDR_W = 4;
	localparam int DATA_W = 16;
	localparam int CNT_W  = 16;
	localparam int CMPP_W = 8;
	localparam int SPAN_W = 17;

	// ==========================================================
	// Register offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL0 = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_CTRL1 = 4'h1;
	localparam logic [ADDR_W-1:0] OFF_COUNT = 4'h2;
	localparam logic [ADDR_W-1:0] OFF_CMPA  = 4'h3;
	localparam logic [ADDR_W-1:0] OFF_CMPP  = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_FLAGS = 4'h5;

	// ==========================================================
	// Bit positions
	localparam int CTRL0_RUN_BIT  = 0;
	localparam int CTRL0_TRIG_BIT = 1;
	localparam int FLAG_A_BIT     = 0;
	localparam int FLAG_P_BIT     = 1;
	localparam int CTRL1_LSB      = 0;
	localparam int CTRL1_MSB      = 7;
	localparam int CMPP_LSB       = 0;
	localparam int CMPP_MSB       = 7;

	// ==========================================================
	// Mode field codes
	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_CAP = 2'h1;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TC  = 2'h3;

	// Pin function codes, compare match
	localparam logic [1:0] PF_NOCHG  = 2'h0;
	localparam logic [1:0] PF_LOW    = 2'h1;
	localparam logic [1:0] PF_HIGH   = 2'h2;
	localparam logic [1:0] PF_TOGGLE = 2'h3;
	// Pin function codes, PWM and single pulse
	localparam logic [1:0] PF_INACT  = 2'h0;
	localparam logic [1:0] PF_ACT    = 2'h1;
	localparam logic [1:0] PF_WAVE   = 2'h2;
	localparam logic [1:0] PF_PULSE  = 2'h3;
	// Pin function codes, capture
	localparam logic [1:0] CAP_RISE  = 2'h0;
	localparam logic [1:0] CAP_FALL  = 2'h1;
	localparam logic [1:0] CAP_BOTH  = 2'h2;
	localparam logic [1:0] CAP_OFF   = 2'h3;

	// ==========================================================
	// Counter constants
	localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
	localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
	localparam logic [CMPP_W-1:0] CMPP_ZERO = 8'h00;
	localparam logic [CMPP_W-1:0] CMPP_ONE  = 8'h01;
	localparam logic [7:0]        LOW_MAX   = 8'hFF;
	localparam logic [SPAN_W-1:0] SPAN_FULL = 17'h10000;
	localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;

	// ==========================================================
	// Carrier types
	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] pin_function;
		logic       output_level_select;
		logic       output_invert;
		logic       duty_period_swap;
		logic       counter_clear_select;
	} stm_ctrl_t;

	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
	} stm_bus_req_t;

	localparam stm_ctrl_t CTRL_RST = 8'h00;

endpackage

// *** design/stm_sync.sv ***
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module stm_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Pin and clean level
	input  wire logic pin_in,
	output var  logic level_out
);

	// ==========================================================
	// Stages
	logic meta_ff;
	logic sync_ff;
	logic hold_ff;

	// First stage feeds only the second
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_ff <= 1'b0;
			sync_ff <= 1'b0;
			hold_ff <= 1'b0;
		end else begin
			meta_ff <= pin_in;
			sync_ff <= meta_ff;
			hold_ff <= sync_ff;
		end
	end

	// Change accepted once stages two and three agree
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			level_out <= 1'b0;
		end else if (sync_ff == hold_ff) begin
			level_out <= hold_ff;
		end
	end

endmodule // stm_sync

`default_nettype wire

// *** design/stm_timer.sv ***
// Standard 16-bit timer: compare, PWM, single pulse, capture, timer modes
`timescale 1ns/1ps
`default_nettype none

module stm_timer (
	// Clock and reset
	input  wire logic                        clk,
	input  wire logic                        arst_n,
	// Register port
	input  wire stm_pkg::stm_bus_req_t       bus_req,
	output var  logic [stm_pkg::DATA_W-1:0]  rdata,
	// External pins
	input  wire logic                        external_clock_trigger_pin,
	input  wire logic                        capture_input_pin,
	output var  logic                        wave_out,
	output var  logic                        wave_oe_n,
	// Status
	output logic                             compare_a_flag,
	output logic                             compare_p_flag
);

	// ==========================================================
	// Declarations
	stm_pkg::stm_ctrl_t              ctrl_ff;
	logic                            counter_run_bit_ff;
	logic                            trig_fall_ff;
	logic                            run_prev_ff;
	logic [stm_pkg::CNT_W-1:0]       cnt_ff;
	logic [stm_pkg::CNT_W-1:0]       compare_value_a_ff;
	logic [stm_pkg::CMPP_W-1:0]      compare_value_p_ff;
	logic                            flag_a_ff;
	logic                            flag_p_ff;
	logic                            out_lvl_ff;
	logic                            trig_prev_ff;
	logic                            cap_prev_ff;
	logic                            trig_lvl;
	logic                            cap_lvl;
	logic                            nxt_run;
	logic [stm_pkg::DATA_W-1:0]      nxt_rdata;
	logic                            nxt_wave;
	logic                            is_cmp;
	logic                            is_pwm;
	logic                            is_sp;
	logic                            is_cap;
	logic                            run_rise;
	logic                            active;
	logic                            a_hit;
	logic                            p_hit;
	logic                            cnt_clr;
	logic                            a_set;
	logic                            p_set;
	logic                            cap_evt;
	logic                            trig_edge;
	logic                            pwm_on;
	logic [stm_pkg::SPAN_W-1:0]      period;
	logic [stm_pkg::SPAN_W-1:0]      duty;
	logic                            wr_ctrl0;
	logic                            wr_ctrl1;
	logic                            wr_cmpa;
	logic                            wr_cmpp;
	logic                            wr_flags;

	// ==========================================================
	// Helpers
	// Zero in a 16-bit compare value means a full 65536-clock span
	function automatic logic [stm_pkg::SPAN_W-1:0] a_span(
		input logic [stm_pkg::CNT_W-1:0] v);
		a_span = (v == stm_pkg::CNT_ZERO) ? stm_pkg::SPAN_FULL
			: {1'b0, v};
	endfunction

	function automatic logic [stm_pkg::SPAN_W-1:0] p_span(
		input logic [stm_pkg::CMPP_W-1:0] v);
		p_span = (v == stm_pkg::CMPP_ZERO) ? stm_pkg::SPAN_FULL
			: {1'b0, v, stm_pkg::LOW_MAX ^ stm_pkg::LOW_MAX};
	endfunction

	function automatic logic is_wr(input stm_pkg::stm_bus_req_t r,
		input logic [stm_pkg::ADDR_W-1:0] off);
		is_wr = r.wr && (r.addr == off);
	endfunction

	// ==========================================================
	// Pin synchronisers
	stm_sync u_trig_sync (
		.clk       (clk),
		.arst_n    (arst_n),
		.pin_in    (external_clock_trigger_pin),
		.level_out (trig_lvl)
	);

	stm_sync u_cap_sync (
		.clk       (clk),
		.arst_n    (arst_n),
		.pin_in    (capture_input_pin),
		.level_out (cap_lvl)
	);

	// ==========================================================
	// Decode
	always_comb begin
		wr_ctrl0 = is_wr(bus_req, stm_pkg::OFF_CTRL0);
		wr_ctrl1 = is_wr(bus_req, stm_pkg::OFF_CTRL1);
		wr_cmpa  = is_wr(bus_req, stm_pkg::OFF_CMPA);
		wr_cmpp  = is_wr(bus_req, stm_pkg::OFF_CMPP);
		wr_flags = is_wr(bus_req, stm_pkg::OFF_FLAGS);
		is_cmp   = (ctrl_ff.mode == stm_pkg::MODE_CMP)
			|| (ctrl_ff.mode == stm_pkg::MODE_TC);
		is_pwm   = (ctrl_ff.mode == stm_pkg::MODE_PWM)
			&& (ctrl_ff.pin_function != stm_pkg::PF_PULSE);
		is_sp    = (ctrl_ff.mode == stm_pkg::MODE_PWM)
			&& (ctrl_ff.pin_function == stm_pkg::PF_PULSE);
		is_cap   = (ctrl_ff.mode == stm_pkg::MODE_CAP);
		run_rise = counter_run_bit_ff && !run_prev_ff;
		active   = counter_run_bit_ff && !run_rise;
	end

	// ==========================================================
	// Comparators
	// Hits fire on the last count of a span so the span is exact
	always_comb begin
		a_hit = active
			&& (cnt_ff == compare_value_a_ff - stm_pkg::CNT_ONE);
		p_hit = active && (cnt_ff[7:0] == stm_pkg::LOW_MAX)
			&& (cnt_ff[15:8] == compare_value_p_ff - stm_pkg::CMPP_ONE);
		unique case (1'b1)
			is_cmp:  cnt_clr = ctrl_ff.counter_clear_select
				? a_hit : p_hit;
			is_pwm:  cnt_clr = ctrl_ff.duty_period_swap
				? a_hit : p_hit;
			is_cap:  cnt_clr = p_hit;
			default: cnt_clr = 1'b0;
		endcase
	end

	// ==========================================================
	// Edge detection
	always_comb begin
		trig_edge = is_sp && (trig_fall_ff ? (!trig_lvl && trig_prev_ff)
			: (trig_lvl && !trig_prev_ff));
		unique case (ctrl_ff.pin_function)
			stm_pkg::CAP_RISE: cap_evt = cap_lvl && !cap_prev_ff;
			stm_pkg::CAP_FALL: cap_evt = !cap_lvl && cap_prev_ff;
			stm_pkg::CAP_BOTH: cap_evt = cap_lvl != cap_prev_ff;
			stm_pkg::CAP_OFF:  cap_evt = 1'b0;
		endcase
		cap_evt = cap_evt && is_cap && counter_run_bit_ff;
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			trig_prev_ff <= 1'b0;
			cap_prev_ff  <= 1'b0;
		end else begin
			trig_prev_ff <= trig_lvl;
			cap_prev_ff  <= cap_lvl;
		end
	end

	// ==========================================================
	// Flags
	always_comb begin
		a_set = (a_hit && (is_pwm || is_sp || (is_cmp
			&& compare_value_a_ff != stm_pkg::CNT_ZERO)))
			|| cap_evt;
		p_set = p_hit && (is_pwm || is_cap
			|| (is_cmp && !ctrl_ff.counter_clear_select));
	end

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			flag_a_ff <= 1'b0;
			flag_p_ff <= 1'b0;
		end else begin
			flag_a_ff <= a_set || (flag_a_ff
				&& !(wr_flags && bus_req.wdata[stm_pkg::FLAG_A_BIT]));
			flag_p_ff <= p_set || (flag_p_ff
				&& !(wr_flags && bus_req.wdata[stm_pkg::FLAG_P_BIT]));
		end
	end

	assign compare_a_flag = flag_a_ff;
	assign compare_p_flag = flag_p_ff;

	// ==========================================================
	// Control registers
	always_comb begin
		nxt_run = counter_run_bit_ff;
		if (wr_ctrl0) begin
			nxt_run = bus_req.wdata[stm_pkg::CTRL0_RUN_BIT];
		end
		if (is_sp && a_hit) begin
			nxt_run = 1'b0;
		end
		if (trig_edge) begin
			nxt_run = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			counter_run_bit_ff <= 1'b0;
			run_prev_ff        <= 1'b0;
			trig_fall_ff       <= 1'b0;
		end else begin
			counter_run_bit_ff <= nxt_run;
			run_prev_ff        <= counter_run_bit_ff;
			if (wr_ctrl0) begin
				trig_fall_ff <= bus_req.wdata[stm_pkg::CTRL0_TRIG_BIT];
			end
		end
	end

	// Mode changes are only safe while the counter is stopped
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_ff <= stm_pkg::CTRL_RST;
		end else if (wr_ctrl1) begin
			ctrl_ff <= bus_req.wdata[stm_pkg::CTRL1_MSB:stm_pkg::CTRL1_LSB];
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			compare_value_p_ff <= stm_pkg::CMPP_ZERO;
		end else if (wr_cmpp) begin
			compare_value_p_ff <= bus_req.wdata[stm_pkg::CMPP_MSB:stm_pkg::CMPP_LSB];
		end
	end

	// Capture beats a software write in the same cycle
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			compare_value_a_ff <= stm_pkg::CNT_ZERO;
		end else if (cap_evt) begin
			compare_value_a_ff <= cnt_ff;
		end else if (wr_cmpa) begin
			compare_value_a_ff <= bus_req.wdata;
		end
	end

	// ==========================================================
	// Counter
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_ff <= stm_pkg::CNT_ZERO;
		end else if (run_rise || (active && cnt_clr)) begin
			cnt_ff <= stm_pkg::CNT_ZERO;
		end else if (active) begin
			cnt_ff <= cnt_ff + stm_pkg::CNT_ONE;
		end
	end

	// ==========================================================
	// Output waveform
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			out_lvl_ff <= 1'b0;
		end else if (is_cmp && run_rise) begin
			out_lvl_ff <= ctrl_ff.output_level_select;
		end else if (is_cmp && a_set) begin
			unique case (ctrl_ff.pin_function)
				stm_pkg::PF_NOCHG:  out_lvl_ff <= out_lvl_ff;
				stm_pkg::PF_LOW:    out_lvl_ff <= 1'b0;
				stm_pkg::PF_HIGH:   out_lvl_ff <= 1'b1;
				stm_pkg::PF_TOGGLE: out_lvl_ff <= !out_lvl_ff;
			endcase
		end
	end

	always_comb begin
		period = ctrl_ff.duty_period_swap ? a_span(compare_value_a_ff)
			: p_span(compare_value_p_ff);
		duty   = ctrl_ff.duty_period_swap ? p_span(compare_value_p_ff)
			: {1'b0, compare_value_a_ff};
		pwm_on = counter_run_bit_ff && ((duty >= period)
			|| ({1'b0, cnt_ff} < duty));
		unique case (1'b1)
			is_cmp: nxt_wave = out_lvl_ff;
			is_sp:  nxt_wave = counter_run_bit_ff
				== ctrl_ff.output_level_select;
			is_pwm: begin
				unique case (ctrl_ff.pin_function)
					stm_pkg::PF_INACT: nxt_wave = !ctrl_ff.output_level_select;
					stm_pkg::PF_ACT:   nxt_wave = ctrl_ff.output_level_select;
					default:           nxt_wave = pwm_on
						== ctrl_ff.output_level_select;
				endcase
			end
			default: nxt_wave = 1'b0;
		endcase
		nxt_wave = nxt_wave ^ ctrl_ff.output_invert;
	end

	// Pin released in timer and capture modes
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			wave_out  <= 1'b0;
			wave_oe_n <= 1'b1;
		end else begin
			wave_out  <= nxt_wave;
			wave_oe_n <= (ctrl_ff.mode == stm_pkg::MODE_TC) || is_cap;
		end
	end

	// ==========================================================
	// Read port
	always_comb begin
		nxt_rdata = stm_pkg::DATA_ZERO;
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				stm_pkg::OFF_CTRL0: begin
					nxt_rdata[stm_pkg::CTRL0_RUN_BIT]  = counter_run_bit_ff;
					nxt_rdata[stm_pkg::CTRL0_TRIG_BIT] = trig_fall_ff;
				end
				stm_pkg::OFF_CTRL1: nxt_rdata[stm_pkg::CTRL1_MSB:stm_pkg::CTRL1_LSB] = ctrl_ff;
				stm_pkg::OFF_COUNT: nxt_rdata = cnt_ff;
				stm_pkg::OFF_CMPA:  nxt_rdata = compare_value_a_ff;
				stm_pkg::OFF_CMPP:  nxt_rdata[stm_pkg::CMPP_MSB:stm_pkg::CMPP_LSB] = compare_value_p_ff;
				stm_pkg::OFF_FLAGS: begin
					nxt_rdata[stm_pkg::FLAG_A_BIT] = flag_a_ff;
					nxt_rdata[stm_pkg::FLAG_P_BIT] = flag_p_ff;
				end
				default: nxt_rdata = stm_pkg::DATA_ZERO;
			endcase
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata <= stm_pkg::DATA_ZERO;
		end else begin
			rdata <= nxt_rdata;
		end
	end

	// ==========================================================
	// Assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	property p_a_clear;
		is_cmp && ctrl_ff.counter_clear_select && active && a_hit
			&& !wr_ctrl1 |=> cnt_ff == stm_pkg::CNT_ZERO;
	endproperty
	a_a_clear: assert property (p_a_clear)
		else $error("counter not cleared on A match");

	property p_no_p_flag;
		is_cmp && ctrl_ff.counter_clear_select |-> !p_set;
	endproperty
	a_no_p_flag: assert property (p_no_p_flag)
		else $error("P flag raised with clear-select set");

	property p_pin_hold;
		is_cmp && !a_set && !run_rise && !wr_ctrl1 |=> $stable(out_lvl_ff);
	endproperty
	a_pin_hold: assert property (p_pin_hold)
		else $error("compare pin moved without A flag");

	property p_tc_release;
		ctrl_ff.mode == stm_pkg::MODE_TC && !wr_ctrl1 |=> wave_oe_n;
	endproperty
	a_tc_release: assert property (p_tc_release)
		else $error("pin driven in timer mode");

	property p_full_duty;
		is_pwm && ctrl_ff.pin_function == stm_pkg::PF_WAVE
			&& counter_run_bit_ff && duty >= period && !wr_ctrl1
			|=> wave_out == (ctrl_ff.output_level_select
				^ ctrl_ff.output_invert);
	endproperty
	a_full_duty: assert property (p_full_duty)
		else $error("PWM not at full duty");

	property p_pwm_runs;
		is_pwm && active && !cnt_clr |=> cnt_ff == $past(cnt_ff) + stm_pkg::CNT_ONE;
	endproperty
	a_pwm_runs: assert property (p_pwm_runs)
		else $error("PWM counter stalled");

	property p_init_level;
		is_cmp && run_rise && !wr_ctrl1
			|=> out_lvl_ff == $past(ctrl_ff.output_level_select);
	endproperty
	a_init_level: assert property (p_init_level)
		else $error("pin not reset to initial level");

	property p_pulse_end;
		is_sp && a_hit && !trig_edge |=> !counter_run_bit_ff ##1 flag_a_ff;
	endproperty
	a_pulse_end: assert property (p_pulse_end)
		else $error("pulse not ended by A match");

	property p_capture;
		cap_evt |=> compare_value_a_ff == $past(cnt_ff) && flag_a_ff;
	endproperty
	a_capture: assert property (p_capture)
		else $error("capture value or flag wrong");

	// Watches the register itself, not the event term it is built from
	property p_cap_off;
		is_cap && ctrl_ff.pin_function == stm_pkg::CAP_OFF && !wr_cmpa
			|=> $stable(compare_value_a_ff);
	endproperty
	a_cap_off: assert property (p_cap_off)
		else $error("capture with capture disabled");

	c_pwm_period: cover property (is_pwm && cnt_clr);
	c_pulse: cover property (is_sp && run_rise ##[1:300] !counter_run_bit_ff);
	c_capture: cover property (cap_evt);
	c_toggle: cover property (is_cmp && a_set
		&& ctrl_ff.pin_function == stm_pkg::PF_TOGGLE);

endmodule // stm_timer

`default_nettype wire

// *** sim/stm_pins_model.sv ***
// Far-side model: trigger and capture pin drivers, output pin with pull-up
`timescale 1ns/1ps
`default_nettype none

module stm_pins_model (
	// Clock and reset
	input  wire logic clk,
	input  wire logic arst_n,
	// Bench requests
	input  wire logic trig_req,
	input  wire logic cap_lvl,
	// Timer side
	input  wire logic wave_out,
	input  wire logic wave_oe_n,
	output var  logic external_clock_trigger_pin,
	output var  logic capture_input_pin,
	output var  logic pin_level
);
	logic [2:0] trig_cnt_ff;

	// ==========================================================
	// Pin drivers
	// Trigger held four cycles so the timer's filter accepts it
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			trig_cnt_ff <= 3'h0;
		end else if (trig_req) begin
			trig_cnt_ff <= 3'h4;
		end else if (trig_cnt_ff != 3'h0) begin
			trig_cnt_ff <= trig_cnt_ff - 3'h1;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			external_clock_trigger_pin <= 1'b0;
			capture_input_pin          <= 1'b0;
		end else begin
			external_clock_trigger_pin <= (trig_cnt_ff != 3'h0);
			capture_input_pin          <= cap_lvl;
		end
	end

	// Released pin floats up to the pull-up level
	assign pin_level = wave_oe_n ? 1'b1 : wave_out;
endmodule // stm_pins_model

`default_nettype wire

// *** sim/tb_standard_timer_operating_modes.sv ***
// Self-checking bench of the standard timer modes
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end

module tb_standard_timer_operating_modes;
	logic                       clk;
	logic                       arst_n;
	stm_pkg::stm_bus_req_t      bus_req;
	logic [stm_pkg::DATA_W-1:0] rdata;
	logic                       trig_pin;
	logic                       cap_pin;
	logic                       wave_out;
	logic                       wave_oe_n;
	logic                       flag_a;
	logic                       flag_p;
	logic                       trig_req;
	logic                       cap_lvl;
	logic                       pin_level;
	logic                       rd_last;
	logic [15:0]                e_note;
	logic [15:0]                exp_q[$];
	logic [31:0]                xs_state;
	int                         n_errors;
	int                         check_count;
	int                         hi;
	logic [7:0]  pw_c1 [7] = '{8'hA8, 8'hAC, 8'hAA, 8'hA8, 8'h88, 8'h98, 8'hA9};
	int          pw_a  [7] = '{0, 64, 300, 300, 64, 64, 64};
	int          pw_win[7] = '{512, 512, 600, 512, 512, 512, 512};
	int          pw_hi [7] = '{0, 384, 512, 512, 0, 512, 128};
	logic [15:0] pw_fl [7] = '{16'h3, 16'h3, 16'h3, 16'h2, 16'h3, 16'h3, 16'h3};

	stm_timer dut_u (
		.clk                        (clk),
		.arst_n                     (arst_n),
		.bus_req                    (bus_req),
		.rdata                      (rdata),
		.external_clock_trigger_pin (trig_pin),
		.capture_input_pin          (cap_pin),
		.wave_out                   (wave_out),
		.wave_oe_n                  (wave_oe_n),
		.compare_a_flag             (flag_a),
		.compare_p_flag             (flag_p)
	);

	stm_pins_model model_u (
		.clk                        (clk),
		.arst_n                     (arst_n),
		.trig_req                   (trig_req),
		.cap_lvl                    (cap_lvl),
		.wave_out                   (wave_out),
		.wave_oe_n                  (wave_oe_n),
		.external_clock_trigger_pin (trig_pin),
		.capture_input_pin          (cap_pin),
		.pin_level                  (pin_level)
	);

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs();
		xs_state ^= xs_state << 13;
		xs_state ^= xs_state >> 17;
		xs_state ^= xs_state << 5;
		return xs_state;
	endfunction

	task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		bus_req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(posedge clk);
		bus_req <= '0;
	endtask

	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		bus(1'b1, a, d);
	endtask

	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 16'h0000);
	endtask

	task automatic run(input logic on);
		wr(stm_pkg::OFF_CTRL0, {15'h0000, on});
	endtask

	task automatic setup(input logic [7:0] c1, input logic [15:0] a,
			input logic [7:0] p);
		run(1'b0);
		wr(stm_pkg::OFF_FLAGS, 16'h0003);
		wr(stm_pkg::OFF_CTRL1, {8'h00, c1});
		wr(stm_pkg::OFF_CMPA, a);
		wr(stm_pkg::OFF_CMPP, {8'h00, p});
	endtask

	task automatic count_high(input int win);
		hi = 0;
		repeat (win) begin
			@(negedge clk);
			hi += int'(pin_level === 1'b1);
		end
	endtask

	task automatic wait_wave(input logic lvl);
		for (int i = 0; i < 50 && wave_out !== lvl; i++) @(negedge clk);
		if (wave_out !== lvl) begin
			n_errors++;
			$display("unexpected at %0t: wait ran out", $time);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask

	// ==========================================================
	// Read data watcher: oldest note against the answer
	always @(negedge clk) begin
		if (rd_last) begin
			if (exp_q.size() == 0) begin
				n_errors++;
				$display("unexpected at %0t: read with no note", $time);
			end else begin
				e_note = exp_q.pop_front();
				`CHK(rdata, e_note)
			end
		end
		rd_last = bus_req.rd;
	end

	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	initial begin
		repeat (100000) @(posedge clk);
		n_errors++;
		$display("unexpected at %0t: run too long", $time);
		end_sim();
	end

	// ==========================================================
	// Scenarios
	initial begin
		arst_n = 1'b0; bus_req = '0; trig_req = 1'b0; cap_lvl = 1'b0;
		rd_last = 1'b0; xs_state = 32'd57845; n_errors = 0; check_count = 0;
		repeat (3) @(posedge clk);
		arst_n <= 1'b1;
		for (int r = 0; r < 6; r++) rd(r[3:0], 16'h0000);
		rd(4'hF, 16'h0000);
		$display("test reset done");

		setup(8'h39, 16'd600, 8'h01);
		run(1'b1);
		repeat (5) @(negedge clk);
		`CHK(wave_out, 1'b1)
		repeat (695) @(negedge clk);
		`CHK(wave_out, 1'b0)
		`CHK({flag_p, flag_a}, 2'b01)
		rd(stm_pkg::OFF_FLAGS, 16'h0001);
		run(1'b0);
		run(1'b1);
		repeat (5) @(negedge clk);
		`CHK(wave_out, 1'b1)
		$display("test compare done");

		setup(8'hC1, 16'd50, 8'h00);
		run(1'b1);
		repeat (120) @(negedge clk);
		`CHK(wave_oe_n, 1'b1)
		rd(stm_pkg::OFF_FLAGS, 16'h0001);
		$display("test timer done");

		for (int k = 0; k < 7; k++) begin
			if (k == 0) begin
				pw_a[0] = int'(xs() % 200) + 1;
				pw_hi[0] = 2 * pw_a[0];
			end
			setup(pw_c1[k], pw_a[k][15:0], 8'h01);
			run(1'b1);
			repeat (300) @(negedge clk);
			count_high(pw_win[k]);
			`CHK(hi, pw_hi[k])
			`CHK({flag_p, flag_a}, pw_fl[k][1:0])
			rd(stm_pkg::OFF_FLAGS, pw_fl[k]);
		end
		$display("test pwm done");

		setup(8'hB8, 16'd40, 8'h00);
		repeat (2) begin
			run(1'b1);
			count_high(80);
			// Run-rise cycle clears the counter, adding one clock
			`CHK(hi, 41)
			rd(stm_pkg::OFF_CTRL0, 16'h0000);
			rd(stm_pkg::OFF_FLAGS, 16'h0001);
		end
		setup(8'hB8, 16'd1000, 8'h00);
		run(1'b1);
		wait_wave(1'b1);
		repeat (50) @(negedge clk);
		run(1'b0);
		wait_wave(1'b0);
		rd(stm_pkg::OFF_FLAGS, 16'h0000);
		for (int f = 0; f < 2; f++) begin
			setup(8'hB8, 16'd40, 8'h00);
			wr(stm_pkg::OFF_CTRL0, {14'h0000, f[0], 1'b0});
			@(posedge clk);
			trig_req <= 1'b1;
			@(posedge clk);
			trig_req <= 1'b0;
			// Falling select acts four clocks after the rising one
			repeat (8) @(negedge clk);
			`CHK(wave_out, !f[0])
			wait_wave(1'b1);
			rd(stm_pkg::OFF_CTRL0, {14'h0000, f[0], 1'b1});
			wait_wave(1'b0);
		end
		$display("test single pulse done");

		for (int m = 0; m < 4; m++) begin
			setup({2'b01, m[1:0], 4'h0}, 16'h0000, 8'h00);
			run(1'b1);
			cap_lvl <= 1'b1;
			repeat (20) @(posedge clk);
			rd(stm_pkg::OFF_FLAGS, {15'h0, m == 0 || m == 2});
			// Pin register, three stages and agreement: count 4
			if (m == 0 || m == 2) rd(stm_pkg::OFF_CMPA, 16'h0004);
			wr(stm_pkg::OFF_FLAGS, 16'h0003);
			cap_lvl <= 1'b0;
			repeat (20) @(posedge clk);
			rd(stm_pkg::OFF_FLAGS, {15'h0, m == 1 || m == 2});
		end
		setup(8'h40, 16'h0000, 8'h01);
		run(1'b1);
		repeat (600) @(posedge clk);
		rd(stm_pkg::OFF_FLAGS, 16'h0002);
		rd(stm_pkg::OFF_CMPA, 16'h0000);
		$display("test capture done");
		repeat (4) @(posedge clk);
		end_sim();
	end
endmodule // tb_standard_timer_operating_modes

`default_nettype wire
